// ---- include/ncocs_regs.svh ----
`ifndef NCOCS_REGS_SVH
`define NCOCS_REGS_SVH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define NCOCS_PRE_DIV_OFS     8'h20
`define NCOCS_PRE_PAT_OFS     8'h24
`define NCOCS_FB_DIV_OFS      8'h28
`define NCOCS_FB_PAT_OFS      8'h2C
`define NCOCS_CTRL_OFS        8'h30
`define NCOCS_SWITCH_OFS      8'h34
`define NCOCS_STATUS_OFS      8'h38
// ----------------------------------------
// field positions
// ----------------------------------------
`define NCOCS_DIV_LEN_LSB     8
`define NCOCS_CTRL_FORCE_BIT  0
`define NCOCS_ST_BOOST_BIT    0
`define NCOCS_ST_PLLSEL_BIT   1
`define NCOCS_ST_ARMED_BIT    2
`define NCOCS_ST_LOCK_BIT     3
// ----------------------------------------
// reset values and counts
// ----------------------------------------
`define NCOCS_PRE_DIV_RST     5'h08
`define NCOCS_FB_DIV_RST      7'h10
`define NCOCS_XTAL_DIV        9
`define NCOCS_FSYNC_WAIT      2
`endif

// ---- include/ncocs_pkg.sv ----
package ncocs_pkg;
   typedef struct packed {
      logic [6:0] divisor;
      logic [2:0] len;
      logic [7:0] pattern;
   } ncocs_div_cfg_t;
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } ncocs_wb_req_t;
   typedef enum logic [1:0] {NCOCS_XTAL, NCOCS_WAIT_LOW, NCOCS_PLL} ncocs_mux_t;
endpackage

// ---- hdl/ncocs_frac_div.sv ----
`timescale 1ns/100ps
module ncocs_frac_div
#(
   parameter int DW = 7
)
(
   input  wire logic                      clk,
   input  wire logic                      rstn,
   input  wire logic                      tick,
   input  wire ncocs_pkg::ncocs_div_cfg_t cfg,
   output logic                           clk_out
);
   import ncocs_pkg::*;
   logic [DW:0] cnt_reg;
   logic [2:0]  idx_reg;
   logic [DW:0] period;
   logic        pbit;
   // ----------------------------------------
   // period select
   // ----------------------------------------
   always_comb
   begin
      pbit   = (cfg.len != 3'h0) && cfg.pattern[idx_reg];                 // [R04]
      period = {1'b0, cfg.divisor[DW-1:0]} + {{DW{1'b0}}, pbit};         // [R03] [R09]
   end
   // integer ratio: same period every time, so no jitter
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         cnt_reg <= '0;
         idx_reg <= 3'h0;
         clk_out <= 1'b0;
      end
      else if (tick && cnt_reg + 1'b1 >= period)
      begin
         cnt_reg <= '0;                                                   // [R05] [R06]
         idx_reg <= (idx_reg == 3'h0) ? cfg.len : idx_reg - 3'h1;         // [R18]
         clk_out <= 1'b1;
      end
      else if (tick)
      begin
         cnt_reg <= cnt_reg + 1'b1;
         if (cnt_reg + 1'b1 >= (period >> 1))
            clk_out <= 1'b0;
      end
   end
endmodule

// ---- hdl/ncocs_top.sv ----
`timescale 1ns/100ps
`include "ncocs_regs.svh"
// How it works
// [R01] crystal clock through prescaler gives pll reference
// [R02] prescaler: 5-bit divisor, 3-bit length, pattern
// [R03] pattern bit 0 divides N, 1 divides N+1
// [R04] pattern spans length+1; zero length plain divide
// [R05] integer ratio gives jitter-free straight divide
// [R06] fractional ratio exact only on average
// [R07] host keeps reference within 2 to 4 MHz
// [R08] feedback: 7-bit divisor, 3-bit length, pattern
// [R09] feedback divider uses same scheme on vco
// [R10] vco runs at 2x2304 sample rate
// [R11] boost charge pump until lock or force
// [R12] pll settles within one frame-sync period
// [R13] host writes rate registers ascending, last one last
// [R14] switch register write commands pll clock switch
// [R15] after reset system clock is crystal/9
// [R16] switch not before second frame sync after commit
// [R17] switch through deglitch multiplexer
// [R18] pattern walked from length bit down to 0
// [R19] mux changes only while both clocks low; leaving XTAL checks only the crystal clock low
module ncocs_top
   import ncocs_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        vco_clk_i,
   input  wire logic        pll_lock_indication,
   input  wire logic        frame_sync_i,
   output logic             pll_ref_o,
   output logic             pll_fb_o,
   output logic             cp_boost_o,
   output logic             sys_clk_o,
   output logic             sample_tick_o
);
   import ncocs_pkg::*;
   localparam int SAMPLE_DIV = 2 * 2304;
   ncocs_div_cfg_t pre_cfg_reg;
   ncocs_div_cfg_t fb_cfg_reg;
   ncocs_wb_req_t  req;
   logic           force_reg;
   logic           armed_reg;
   logic           switch_req_reg;
   logic [1:0]     fs_cnt_reg;
   logic [2:0]     vco_sync_reg;
   logic [1:0]     lock_sync_reg;
   logic [2:0]     fs_sync_reg;
   logic [3:0]     xdiv_reg;
   logic           xclk_reg;
   logic           pll_clk;
   logic           pre_clk;
   logic           fb_clk;
   logic [12:0]    samp_cnt_reg;
   ncocs_mux_t     mux_reg;
   logic           wr;
   logic           vco_rise;
   logic           fs_rise;

   assign req      = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i};
   assign wr       = req.cyc && req.stb && req.we && !wb_ack_o;
   assign vco_rise = vco_sync_reg[1] && !vco_sync_reg[2];
   assign fs_rise  = fs_sync_reg[1] && !fs_sync_reg[2];
   assign pll_clk  = vco_sync_reg[1];
   // ----------------------------------------
   // input synchronisers
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         vco_sync_reg  <= 3'h0;
         lock_sync_reg <= 2'h0;
         fs_sync_reg   <= 3'h0;
      end
      else
      begin
         vco_sync_reg  <= {vco_sync_reg[1:0], vco_clk_i};
         lock_sync_reg <= {lock_sync_reg[0], pll_lock_indication};
         fs_sync_reg   <= {fs_sync_reg[1:0], frame_sync_i};
      end
   end
   // ----------------------------------------
   // wishbone slave
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= req.cyc && req.stb && !wb_ack_o;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pre_cfg_reg <= '{7'(`NCOCS_PRE_DIV_RST), 3'h0, 8'h00};
         fb_cfg_reg  <= '{`NCOCS_FB_DIV_RST, 3'h0, 8'h00};
         force_reg   <= 1'b0;
      end
      else if (wr)
      begin
         case (req.adr)
            `NCOCS_PRE_DIV_OFS:
            begin
               if (req.sel[0])
                  pre_cfg_reg.divisor <= {2'h0, req.dat[4:0]};             // [R02]
               if (req.sel[1])
                  pre_cfg_reg.len <= req.dat[`NCOCS_DIV_LEN_LSB +: 3];
            end
            `NCOCS_PRE_PAT_OFS:
               if (req.sel[0])
                  pre_cfg_reg.pattern <= req.dat[7:0];
            `NCOCS_FB_DIV_OFS:
            begin
               if (req.sel[0])
                  fb_cfg_reg.divisor <= req.dat[6:0];                      // [R08]
               if (req.sel[1])
                  fb_cfg_reg.len <= req.dat[`NCOCS_DIV_LEN_LSB +: 3];
            end
            `NCOCS_FB_PAT_OFS:
               if (req.sel[0])
                  fb_cfg_reg.pattern <= req.dat[7:0];
            `NCOCS_CTRL_OFS:
               if (req.sel[0])
                  force_reg <= req.dat[`NCOCS_CTRL_FORCE_BIT];
            default:
               force_reg <= force_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         wb_dat_o <= 32'h0000_0000;
      else if (req.cyc && req.stb && !req.we && !wb_ack_o)
      begin
         case (req.adr)
            `NCOCS_PRE_DIV_OFS: wb_dat_o <= {21'h0, pre_cfg_reg.len, 3'h0, pre_cfg_reg.divisor[4:0]};
            `NCOCS_PRE_PAT_OFS: wb_dat_o <= {24'h0, pre_cfg_reg.pattern};
            `NCOCS_FB_DIV_OFS:  wb_dat_o <= {21'h0, fb_cfg_reg.len, 1'b0, fb_cfg_reg.divisor};
            `NCOCS_FB_PAT_OFS:  wb_dat_o <= {24'h0, fb_cfg_reg.pattern};
            `NCOCS_CTRL_OFS:    wb_dat_o <= {31'h0, force_reg};
            `NCOCS_STATUS_OFS:  wb_dat_o <= {28'h0, lock_sync_reg[1], armed_reg,
                                             (mux_reg == NCOCS_PLL), cp_boost_o};
            default:            wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end
   // ----------------------------------------
   // dividers
   // ----------------------------------------
   ncocs_frac_div #(.DW(7)) u_pre
   (
      .clk     (ref_clk),
      .rstn    (rstn),
      .tick    (1'b1),
      .cfg     (pre_cfg_reg),
      .clk_out (pre_clk)
   );                                                                     // [R01]

   // feedback counts vco edges seen in the system domain; vco must be below ref_clk/2
   logic fb_tick_reg;
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         fb_tick_reg <= 1'b0;
      else
         fb_tick_reg <= vco_rise;
   end

   ncocs_frac_div #(.DW(7)) u_fb
   (
      .clk     (ref_clk),
      .rstn    (rstn),
      .tick    (fb_tick_reg),
      .cfg     (fb_cfg_reg),
      .clk_out (fb_clk)
   );                                                                     // [R09]

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         pll_ref_o <= 1'b0;
         pll_fb_o  <= 1'b0;
      end
      else
      begin
         pll_ref_o <= pre_clk;
         pll_fb_o  <= fb_clk;
      end
   end
   // ----------------------------------------
   // sample tick from vco
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         samp_cnt_reg  <= 13'h0000;
         sample_tick_o <= 1'b0;
      end
      else
      begin
         sample_tick_o <= 1'b0;
         if (vco_rise)
         begin
            if (samp_cnt_reg == 13'(SAMPLE_DIV - 1))
            begin
               samp_cnt_reg  <= 13'h0000;
               sample_tick_o <= 1'b1;                                     // [R10]
            end
            else
               samp_cnt_reg <= samp_cnt_reg + 13'h0001;
         end
      end
   end
   // ----------------------------------------
   // charge pump boost
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         cp_boost_o <= 1'b1;
      else if (wr && req.adr == `NCOCS_FB_PAT_OFS)
         cp_boost_o <= 1'b1;                                              // [R12]
      else if (lock_sync_reg[1] || force_reg)
         cp_boost_o <= 1'b0;                                              // [R11]
   end

   a_boost_drops: assert property (@(posedge ref_clk) disable iff (!rstn)
      (force_reg && !wr) |=> !cp_boost_o)                                 // [R11]
      else $error("boost still high with force set");
   // ----------------------------------------
   // switch arming: two frame syncs after commit
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         fs_cnt_reg <= 2'h0;
         armed_reg  <= 1'b0;
      end
      else if (wr && req.adr == `NCOCS_FB_PAT_OFS)
      begin
         fs_cnt_reg <= 2'h0;                                              // [R13]
         armed_reg  <= 1'b0;
      end
      else if (fs_rise && !armed_reg)
      begin
         fs_cnt_reg <= fs_cnt_reg + 2'h1;
         if (fs_cnt_reg + 2'h1 >= 2'(`NCOCS_FSYNC_WAIT))
            armed_reg <= 1'b1;                                            // [R16]
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         switch_req_reg <= 1'b0;
      else if (wr && req.adr == `NCOCS_SWITCH_OFS)
         switch_req_reg <= 1'b1;                                          // [R14]
   end
   // ----------------------------------------
   // crystal / 9 default clock
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
      begin
         xdiv_reg <= 4'h0;
         xclk_reg <= 1'b0;
      end
      else if (xdiv_reg == 4'(`NCOCS_XTAL_DIV - 1))
      begin
         xdiv_reg <= 4'h0;
         xclk_reg <= 1'b1;                                                // [R15]
      end
      else
      begin
         xdiv_reg <= xdiv_reg + 4'h1;
         if (xdiv_reg == 4'(`NCOCS_XTAL_DIV / 2 - 1))
            xclk_reg <= 1'b0;
      end
   end
   // ----------------------------------------
   // deglitch mux
   // ----------------------------------------
   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         mux_reg <= NCOCS_XTAL;
      else
      begin
         unique case (mux_reg)
            NCOCS_XTAL:
               if (switch_req_reg && armed_reg && !xclk_reg)
                  mux_reg <= NCOCS_WAIT_LOW;                              // [R17]
            NCOCS_WAIT_LOW:
               if (!xclk_reg && !pll_clk)
                  mux_reg <= NCOCS_PLL;                                   // [R19]
            NCOCS_PLL:
               mux_reg <= NCOCS_PLL;
            default:
               mux_reg <= NCOCS_XTAL;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rstn)
         sys_clk_o <= 1'b0;
      else
      begin
         unique case (mux_reg)
            NCOCS_XTAL:     sys_clk_o <= xclk_reg;
            NCOCS_WAIT_LOW: sys_clk_o <= 1'b0;                            // [R19]
            NCOCS_PLL:      sys_clk_o <= pll_clk;
            default:        sys_clk_o <= 1'b0;
         endcase
      end
   end

   a_no_early_sw: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mux_reg == NCOCS_XTAL && !armed_reg) |=> mux_reg != NCOCS_WAIT_LOW) // [R16]
      else $error("switch started before arming");
   a_low_in_gap: assert property (@(posedge ref_clk) disable iff (!rstn)
      (mux_reg == NCOCS_WAIT_LOW) |=> !sys_clk_o)                         // [R19]
      else $error("system clock not low during switch");
   a_xtal_period: assert property (@(posedge ref_clk) disable iff (!rstn)
      $rose(xclk_reg) |-> ##9 $rose(xclk_reg))                           // [R15]
      else $error("default clock period not nine");
   a_wb_ack_once: assert property (@(posedge ref_clk) disable iff (!rstn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
   a_sample_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
      sample_tick_o |=> !sample_tick_o)                                   // [R10]
      else $error("sample tick too long");
   a_sw_cmd: assert property (@(posedge ref_clk) disable iff (!rstn)
      (wr && req.adr == `NCOCS_SWITCH_OFS) |=> switch_req_reg)            // [R14]
      else $error("switch command lost");
   a_arm_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
      (wr && req.adr == `NCOCS_FB_PAT_OFS) |=> !armed_reg && cp_boost_o)  // [R13]
      else $error("commit did not rearm");
endmodule

// ---- verif/ncocs_pll_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// analog pll and framing stand-in
// ----------------------------------------
module ncocs_pll_model
(
   input  wire logic ref_clk,
   input  wire logic lock_req,
   output logic      vco_clk,
   output logic      pll_lock_indication,
   output logic      frame_sync
);
   int fs_cnt;
   // free-running vco at three ref cycles: under half ref_clk, fixed phase
   // 3 ns offset so vco edges never meet ref_clk edges
   initial
   begin
      vco_clk = 1'b0;
      #3;
      forever #75 vco_clk = ~vco_clk;
   end
   // lock follows the bench one cycle later
   always_ff @(posedge ref_clk)
   begin
      pll_lock_indication <= lock_req;
   end
   // frame sync every 600 cycles, wide enough for a 3-flop sync
   always_ff @(posedge ref_clk)
   begin
      fs_cnt     <= (fs_cnt >= 599) ? 0 : fs_cnt + 1;
      frame_sync <= (fs_cnt < 5);
   end
endmodule

// ---- verif/nco_clock_synthesis_control_tb_top.sv ----
`timescale 1ns/100ps
`include "ncocs_regs.svh"
module nco_clock_synthesis_control_tb_top;
   import ncocs_pkg::*;
   logic          ref_clk = 1'b0;
   logic          rstn = 1'b0;
   logic          lock_req = 1'b0;
   ncocs_wb_req_t req = '0;
   logic [31:0]   wb_dat_o;
   logic [31:0]   rd;
   logic          wb_ack_o;
   logic          vco_clk;
   logic          pll_lock_indication;
   logic          frame_sync;
   logic          pll_ref_o;
   logic          pll_fb_o;
   logic          cp_boost_o;
   logic          sys_clk_o;
   logic          sample_tick_o;
   int            errors;
   int            check_count;
   int            vco_cnt;
   int            per[$];

   always #25 ref_clk = ~ref_clk;
   always @(posedge vco_clk) vco_cnt++;

   ncocs_top i_dut (.ref_clk(ref_clk), .rstn(rstn), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
      .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vco_clk_i(vco_clk),
      .pll_lock_indication(pll_lock_indication), .frame_sync_i(frame_sync),
      .pll_ref_o(pll_ref_o), .pll_fb_o(pll_fb_o), .cp_boost_o(cp_boost_o),
      .sys_clk_o(sys_clk_o), .sample_tick_o(sample_tick_o));

   ncocs_pll_model i_pll (.ref_clk(ref_clk), .lock_req(lock_req), .vco_clk(vco_clk),
      .pll_lock_indication(pll_lock_indication), .frame_sync(frame_sync));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task test_done;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   // one classic cycle; called just after an edge, ends just after one
   task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      req <= '{1'b1, 1'b1, we, a, 4'hF, d};
      @(posedge ref_clk);
      while (wb_ack_o !== 1'b1) @(posedge ref_clk);
      rd = wb_dat_o;
      req <= '0;
      @(posedge ref_clk);
   endtask

   // rise-to-rise spacing: ref cycles for 0/1, vco rises for 2/3
   task get_per(input int which, input int n);
      logic s;
      logic prv;
      int   t;
      int   last;
      per.delete();
      prv = 1'b1;
      t = 0;
      last = -1;
      while (per.size() < n)
      begin
         @(posedge ref_clk);
         t = (which >= 2) ? vco_cnt : t + 1;
         s = (which == 0) ? pll_ref_o : (which == 1) ? sys_clk_o : (which == 2) ? pll_fb_o : sample_tick_o;
         if (s === 1'b1 && prv === 1'b0)
         begin
            if (last >= 0) per.push_back(t - last);
            last = t;
         end
         prv = s;
      end
   endtask

   // early periods skipped: a new setting may land mid-pattern
   task chk_seq(input string name, input int which, input int e[$]);
      int s;
      get_per(which, 6 + 2 * e.size());
      s = 3;
      while (s < per.size() - e.size() && !(per[s] == e[0] && per[s + 1] == e[1])) s++;
      foreach (e[i]) chk(name, e[i], per[s + i]);
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      chk("boost reset", 1, cp_boost_o);
      wb(0, `NCOCS_STATUS_OFS, 0);
      chk("status reset", 32'h1, rd);
      wb(0, `NCOCS_PRE_DIV_OFS, 0);
      chk("pre div reset", 32'h8, rd);
      wb(0, `NCOCS_FB_DIV_OFS, 0);
      chk("fb div reset", 32'h10, rd);
      chk_seq("xtal div", 1, '{9, 9, 9});
      wb(1, 8'h3C, 32'hFFFF_FFFF);
      wb(0, 8'h3C, 0);
      chk("unmapped", 32'h0, rd);
      // zero length ignores an all-ones pattern; 2 MHz reference
      wb(1, `NCOCS_PRE_DIV_OFS, 32'h0000_000A);
      wb(1, `NCOCS_PRE_PAT_OFS, 32'h0000_00FF);
      chk_seq("int div", 0, '{10, 10, 10});
      // pattern chosen so a reversed walk or swapped bit meaning shows
      wb(1, `NCOCS_PRE_DIV_OFS, 32'h0000_0708);
      wb(0, `NCOCS_PRE_DIV_OFS, 0);
      chk("pre cfg", 32'h708, rd);
      wb(1, `NCOCS_PRE_PAT_OFS, 32'h0000_00D0);
      chk_seq("frac div", 0, '{9, 9, 8, 9, 8, 8, 8, 8});
      wb(1, `NCOCS_FB_DIV_OFS, 32'h0000_0405);
      wb(1, `NCOCS_FB_PAT_OFS, 32'h0000_0001);
      chk_seq("fb div", 2, '{6, 5, 5, 5, 5});
      wb(1, `NCOCS_CTRL_OFS, 32'h1);
      repeat (4) @(posedge ref_clk);
      chk("boost forced", 0, cp_boost_o);
      wb(1, `NCOCS_CTRL_OFS, 32'h0);
      wb(1, `NCOCS_FB_PAT_OFS, 32'h0000_0001);
      repeat (4) @(posedge ref_clk);
      chk("boost restart", 1, cp_boost_o);
      lock_req <= 1'b1;
      repeat (8) @(posedge ref_clk);
      chk("boost locked", 0, cp_boost_o);
      // keep clear of a sync edge so both sides count the same rises
      @(posedge frame_sync);
      repeat (20) @(posedge ref_clk);
      wb(1, `NCOCS_FB_PAT_OFS, 32'h0000_0001);
      wb(1, `NCOCS_SWITCH_OFS, 32'h0);
      @(posedge frame_sync);
      repeat (20) @(posedge ref_clk);
      wb(0, `NCOCS_STATUS_OFS, 0);
      chk("one sync", 32'h8, rd);
      chk_seq("xtal kept", 1, '{9, 9});
      @(posedge frame_sync);
      repeat (20) @(posedge ref_clk);
      wb(0, `NCOCS_STATUS_OFS, 0);
      chk("switched", 32'hE, rd);
      get_per(1, 4);
      foreach (per[i]) chk("pll sysclk", 3, per[i]);
      get_per(3, 1);
      chk("sample tick", 4608, per[0]);
      test_done;
   end

   initial
   begin
      repeat (60000) @(posedge ref_clk);
      errors++;
      test_done;
   end
endmodule
